// file: cns_core.sv
// Conditional normalize shift core with accumulators and status registers
// Behaviour
// - A zero forty-bit accumulator sets the selected test flag.
// - Nonzero with two equal sign bits shifts the accumulator left one and clears the flag.
// - Nonzero with differing sign bits leaves it unshifted and sets the flag.
// - Sign bits are taken from positions 31 and 30.
// - The shift runs correctly on every iteration of a repeat loop.
// - Protected status address ignores writes to cache bits and reads them zero.
// - Status fields take their listed values after reset.
// - Micro mode select loads from a strap pin, synchronized and captured at the third clock edge after reset is released.
// - Writing the cache control bits flushes the pipeline for five cycles.
`timescale 1ns/1ps
`default_nettype none
module cns_core #(
  parameter int NUM_ACC = 4
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic [cns_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [cns_pkg::REG_W-1:0]    regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [cns_pkg::REG_W-1:0]    regRdData,
  input  wire logic                         instrValid,
  input  wire logic [$clog2(NUM_ACC)-1:0]   instrAccSel,
  input  wire logic                         instrFlagSel,
  input  wire logic [cns_pkg::REP_W-1:0]    instrRepeat,
  output logic                              instrReady,
  input  wire logic                         microStrap,
  output logic                              busy,
  output logic                              pipeFlush,
  output logic                              testFlagOne,
  output logic                              testFlagTwo,
  output logic                              cacheOn,
  output logic                              cacheFreeze,
  output logic                              legacyCompat,
  output logic                              debugMask
);
  localparam int SEL_W = $clog2(NUM_ACC);

  if (NUM_ACC < 2 || NUM_ACC > 4) begin : gBadAccCount
    $error("NUM_ACC must be 2 to 4");
  end

  logic [cns_pkg::ACC_W-1:0] acc_ff [NUM_ACC];
  logic [cns_pkg::REG_W-1:0] arith_ff;
  logic [cns_pkg::REG_W-1:0] sysctl_ff;
  logic [cns_pkg::REG_W-1:0] cache_ff;
  logic                      flagOne_ff;
  logic                      flagTwo_ff;
  cns_pkg::cns_exec_t        state_ff;
  logic [SEL_W-1:0]          execAcc_ff;
  logic                      execFlag_ff;
  logic [cns_pkg::REP_W-1:0] repCnt_ff;
  logic [cns_pkg::CNT_W-1:0] flushCnt_ff;
  logic                      flush_ff;
  logic [cns_pkg::REG_W-1:0] rdData_ff;
  logic                      strapMeta_ff;
  logic                      strapSync_ff;
  logic [1:0]                capCnt_ff;

  cns_shift_if shIf ();

  cns_shifter uShifter (
    .sh (shIf)
  );

  // Accumulator word decode shared by the read and write paths
  function automatic logic accHit(input logic [cns_pkg::ADDR_W-1:0] a);
    logic [cns_pkg::ADDR_W-1:0] rel;
    rel = a - cns_pkg::ADR_ACC_BASE;
    accHit = (a >= cns_pkg::ADR_ACC_BASE) && (a[1:0] == 2'h0)
             && ((rel >> cns_pkg::ACC_STRIDE_SH) < NUM_ACC);
  endfunction

  function automatic logic [SEL_W-1:0] accIdx(input logic [cns_pkg::ADDR_W-1:0] a);
    logic [cns_pkg::ADDR_W-1:0] rel;
    rel = (a - cns_pkg::ADR_ACC_BASE) >> cns_pkg::ACC_STRIDE_SH;
    accIdx = rel[SEL_W-1:0];
  endfunction

  logic execFire;
  logic cacheWr;
  logic protWr;
  logic issue;

  assign busy       = (flushCnt_ff != '0);
  assign execFire   = (state_ff == cns_pkg::CNS_RUN) && !busy;
  assign instrReady = (state_ff == cns_pkg::CNS_IDLE) && !busy;
  assign issue      = instrValid && instrReady;
  assign cacheWr    = regWr && (regAddr == cns_pkg::ADR_CACHE);
  assign protWr     = regWr && (regAddr == cns_pkg::ADR_CACHE_PROT);
  assign shIf.acc   = acc_ff[execAcc_ff];

  // Repeat loop sequencing; a flush stalls the loop instead of losing an iteration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= cns_pkg::CNS_IDLE;
      execAcc_ff  <= '0;
      execFlag_ff <= 1'b0;
      repCnt_ff   <= '0;
    end else begin
      case (state_ff)
        cns_pkg::CNS_IDLE: begin
          if (issue) begin
            state_ff    <= cns_pkg::CNS_RUN;
            execAcc_ff  <= instrAccSel;
            execFlag_ff <= instrFlagSel;
            repCnt_ff   <= instrRepeat;
          end
        end
        cns_pkg::CNS_RUN: begin
          if (execFire) begin
            if (repCnt_ff == '0) begin
              state_ff <= cns_pkg::CNS_IDLE;
            end else begin
              repCnt_ff <= repCnt_ff - 1'b1;
            end
          end
        end
        default: begin
          state_ff <= cns_pkg::CNS_IDLE;
        end
      endcase
    end
  end

  // Accumulators: the shift step wins over a software write to the same word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_ff[i] <= '0;
      end
    end else begin
      if (regWr && accHit(regAddr)) begin
        if (regAddr[cns_pkg::ACC_HI_BIT]) begin
          acc_ff[accIdx(regAddr)][cns_pkg::ACC_W-1:32] <= regWrData[7:0];
        end else begin
          acc_ff[accIdx(regAddr)][31:16] <= regWrData;
          acc_ff[accIdx(regAddr)][15:0]  <= 16'h0000;
        end
      end
      if (execFire) begin
        acc_ff[execAcc_ff] <= shIf.result;
      end
    end
  end

  // Test flags: the shift outcome wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flagOne_ff <= 1'b1;
      flagTwo_ff <= 1'b1;
    end else begin
      if (regWr && regAddr == cns_pkg::ADR_FLAGS) begin
        flagOne_ff <= regWrData[cns_pkg::FLAG_ONE_BIT];
        flagTwo_ff <= regWrData[cns_pkg::FLAG_TWO_BIT];
      end
      if (execFire && !execFlag_ff) begin
        flagOne_ff <= shIf.flag;
      end
      if (execFire && execFlag_ff) begin
        flagTwo_ff <= shIf.flag;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arith_ff  <= cns_pkg::RST_ARITH;
      sysctl_ff <= cns_pkg::RST_SYSCTL;
    end else begin
      if (regWr && regAddr == cns_pkg::ADR_ARITH) begin
        arith_ff <= regWrData;
      end
      if (regWr && regAddr == cns_pkg::ADR_SYSCTL) begin
        sysctl_ff <= regWrData & cns_pkg::SYSCTL_RW_MASK;
      end
    end
  end

  // The strap is a pin: two flops before the capture logic looks at it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strapMeta_ff <= 1'b0;
      strapSync_ff <= 1'b0;
      capCnt_ff    <= '0;
    end else begin
      strapMeta_ff <= microStrap;
      strapSync_ff <= strapMeta_ff;
      if (capCnt_ff != cns_pkg::CAP_DONE) begin
        capCnt_ff <= capCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cache_ff <= cns_pkg::RST_CACHE;
    end else begin
      if (protWr) begin
        cache_ff <= (cache_ff & cns_pkg::CACHE_PROT_MASK)
                    | (regWrData & ~cns_pkg::CACHE_PROT_MASK);
      end else if (cacheWr) begin
        cache_ff <= regWrData;
      end
      if (capCnt_ff == cns_pkg::CAP_LOAD) begin
        cache_ff[cns_pkg::MICRO_BIT] <= strapSync_ff;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flushCnt_ff <= '0;
      flush_ff    <= 1'b0;
    end else begin
      flush_ff <= cacheWr;
      if (cacheWr) begin
        flushCnt_ff <= cns_pkg::FLUSH_LOAD;
      end else if (busy) begin
        flushCnt_ff <= flushCnt_ff - 1'b1;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= '0;
      if (regRd) begin
        if (regAddr == cns_pkg::ADR_ARITH) begin
          rdData_ff <= arith_ff;
        end else if (regAddr == cns_pkg::ADR_SYSCTL) begin
          rdData_ff <= sysctl_ff;
        end else if (regAddr == cns_pkg::ADR_CACHE) begin
          rdData_ff <= cache_ff;
        end else if (regAddr == cns_pkg::ADR_CACHE_PROT) begin
          rdData_ff <= cache_ff & ~cns_pkg::CACHE_PROT_MASK;
        end else if (regAddr == cns_pkg::ADR_FLAGS) begin
          rdData_ff <= {14'h0000, flagTwo_ff, flagOne_ff};
        end else if (regAddr == cns_pkg::ADR_STATE) begin
          rdData_ff <= {14'h0000, (state_ff == cns_pkg::CNS_RUN), busy};
        end else if (accHit(regAddr)) begin
          if (regAddr[cns_pkg::ACC_HI_BIT]) begin
            rdData_ff <= {8'h00, acc_ff[accIdx(regAddr)][cns_pkg::ACC_W-1:32]};
          end else begin
            rdData_ff <= acc_ff[accIdx(regAddr)][31:16];
          end
        end
      end
    end
  end

  assign regRdData    = rdData_ff;
  assign pipeFlush    = flush_ff;
  assign testFlagOne  = flagOne_ff;
  assign testFlagTwo  = flagTwo_ff;
  assign cacheOn      = cache_ff[cns_pkg::CACHE_ON_BIT];
  assign cacheFreeze  = cache_ff[cns_pkg::FREEZE_BIT];
  assign legacyCompat = arith_ff[cns_pkg::LEGACY_BIT];
  assign debugMask    = sysctl_ff[cns_pkg::DEBUG_BIT];

  // Helper state seen only by the checks below
  logic [cns_pkg::ACC_W-1:0] lastAcc_ff;
  logic [SEL_W-1:0]          lastSel_ff;
  logic                      lastFlag_ff;
  logic                      lastFire_ff;
  logic                      rstDone_ff;
  logic [8:0]                fires_ff;
  logic [8:0]                wantFires_ff;
  logic                      selFlag;
  logic [cns_pkg::ACC_W-1:0] lastDest;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastAcc_ff   <= '0;
      lastSel_ff   <= '0;
      lastFlag_ff  <= 1'b0;
      lastFire_ff  <= 1'b0;
      rstDone_ff   <= 1'b0;
      fires_ff     <= '0;
      wantFires_ff <= '0;
    end else begin
      lastAcc_ff  <= shIf.acc;
      lastSel_ff  <= execAcc_ff;
      lastFlag_ff <= execFlag_ff;
      lastFire_ff <= execFire;
      rstDone_ff  <= 1'b1;
      if (issue) begin
        fires_ff     <= '0;
        wantFires_ff <= {1'b0, instrRepeat} + 9'h001;
      end else if (execFire) begin
        fires_ff <= fires_ff + 9'h001;
      end
    end
  end

  assign selFlag  = lastFlag_ff ? flagTwo_ff : flagOne_ff;
  assign lastDest = acc_ff[lastSel_ff];

  sequence cacheWrite_s;
    cacheWr && !protWr;
  endsequence
  sequence stall5_s;
    busy[*5];
  endsequence

  AST_ZERO_SETS_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
    (lastFire_ff && lastAcc_ff == '0) |-> (selFlag && lastDest == '0))
    else $error("zero accumulator did not set flag");
  AST_EQUAL_SIGN_SHIFTS: assert property (@(posedge mclk) disable iff (!rst_n)
    (lastFire_ff && lastAcc_ff != '0 && lastAcc_ff[31] == lastAcc_ff[30])
    |-> (!selFlag && lastDest == {lastAcc_ff[38:0], 1'b0}))
    else $error("equal sign bits did not shift");
  AST_DIFF_SIGN_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
    (lastFire_ff && lastAcc_ff[31] != lastAcc_ff[30]) |-> (selFlag && lastDest == lastAcc_ff))
    else $error("differing sign bits changed accumulator");
  AST_SIGN_POSITIONS: assert property (@(posedge mclk) disable iff (!rst_n)
    execFire |-> (shIf.flag == ((shIf.acc == '0) || (shIf.acc[31] ^ shIf.acc[30]))))
    else $error("flag does not follow bits 31 and 30");
  AST_REPEAT_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(state_ff == cns_pkg::CNS_RUN) |-> (fires_ff == wantFires_ff))
    else $error("repeat loop ran a wrong number of steps");
  AST_PROT_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
    (protWr && !cacheWr) |=> (cache_ff[15:13] == $past(cache_ff[15:13])))
    else $error("protected write changed cache bits");
  AST_PROT_READ_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (regRd && regAddr == cns_pkg::ADR_CACHE_PROT) |=> (regRdData[15:13] == 3'h0))
    else $error("protected read showed cache bits");
  AST_RESET_VALUES: assert property (@(posedge mclk) disable iff (!rst_n)
    !rstDone_ff |-> (arith_ff == cns_pkg::RST_ARITH && sysctl_ff == cns_pkg::RST_SYSCTL
                     && cache_ff[15:12] == cns_pkg::RST_CACHE[15:12]))
    else $error("status register not at reset value");
  AST_STRAP_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
    (capCnt_ff == cns_pkg::CAP_LOAD && !regWr)
    |=> (cache_ff[cns_pkg::MICRO_BIT] == $past(strapSync_ff)))
    else $error("micro mode bit missed the strap");
  AST_FLUSH_STALL: assert property (@(posedge mclk) disable iff (!rst_n)
    cacheWrite_s |=> pipeFlush ##0 stall5_s)
    else $error("cache write did not stall five cycles");
  AST_FLUSH_BLOCKS_ISSUE: assert property (@(posedge mclk) disable iff (!rst_n)
    busy |-> (!instrReady && !execFire))
    else $error("instruction accepted during flush");
endmodule
`default_nettype wire

// file: cns_pkg.sv
// Constants, register map and types for the conditional normalize shift block
`default_nettype none
package cns_pkg;
  localparam int ACC_W     = 40;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 8;
  localparam int REP_W     = 8;
  localparam int SIGN_HI   = 31;
  localparam int SIGN_LO   = 30;

  localparam logic [ADDR_W-1:0] ADR_ARITH      = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_SYSCTL     = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_CACHE      = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_CACHE_PROT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADR_FLAGS      = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_STATE      = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_ACC_BASE   = 8'h20;
  localparam int                ACC_STRIDE_SH  = 3;
  localparam int                ACC_HI_BIT     = 2;

  localparam logic [REG_W-1:0] RST_ARITH       = 16'h2920;
  localparam logic [REG_W-1:0] RST_SYSCTL      = 16'h1000;
  localparam logic [REG_W-1:0] RST_CACHE       = 16'h1C00;
  localparam logic [REG_W-1:0] SYSCTL_RW_MASK  = 16'h9DFF;
  localparam logic [REG_W-1:0] CACHE_PROT_MASK = 16'hE000;

  localparam int LEGACY_BIT   = 5;
  localparam int DEBUG_BIT    = 12;
  localparam int FREEZE_BIT   = 15;
  localparam int CACHE_ON_BIT = 14;
  localparam int FLUSH_BIT    = 13;
  localparam int HOST_IRQ_BIT = 12;
  localparam int MICRO_BIT    = 6;

  localparam int FLAG_ONE_BIT   = 0;
  localparam int FLAG_TWO_BIT   = 1;
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_RUN_BIT  = 1;

  localparam int               FLUSH_CYCLES = 5;
  localparam int               CNT_W        = 3;
  localparam logic [CNT_W-1:0] FLUSH_LOAD   = 3'h5;
  localparam logic [1:0]       CAP_LOAD     = 2'h2;
  localparam logic [1:0]       CAP_DONE     = 2'h3;

  typedef enum logic [0:0] {
    CNS_IDLE = 1'b0,
    CNS_RUN  = 1'b1
  } cns_exec_t;
endpackage
`default_nettype wire

// file: cns_shift_if.sv
// Connection between the core and the conditional shift unit
`timescale 1ns/1ps
`default_nettype none
interface cns_shift_if;
  logic [cns_pkg::ACC_W-1:0] acc;
  logic [cns_pkg::ACC_W-1:0] result;
  logic                      flag;
  modport core (output acc, input result, input flag);
  modport unit (input acc, output result, output flag);
endinterface
`default_nettype wire

// file: cns_shifter.sv
// Combinational one-step normalizing shift with its test-flag outcome
`timescale 1ns/1ps
`default_nettype none
module cns_shifter (
  cns_shift_if.unit sh
);
  logic isZero;
  logic twoSign;

  assign isZero  = (sh.acc == '0);
  assign twoSign = (sh.acc[cns_pkg::SIGN_HI] == sh.acc[cns_pkg::SIGN_LO]);

  always_comb begin
    sh.result = sh.acc;
    sh.flag   = 1'b1;
    if (isZero) begin
      sh.result = sh.acc;
      sh.flag   = 1'b1;
    end else if (twoSign) begin
      sh.result = {sh.acc[cns_pkg::ACC_W-2:0], 1'b0};
      sh.flag   = 1'b0;
    end else begin
      sh.result = sh.acc;
      sh.flag   = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb_conditional_normalize_shift.sv
// Self-checking bench for the conditional normalize shift core
`timescale 1ns/1ps
`default_nettype none
module tb_conditional_normalize_shift;
  logic        mclk, rst_n, regWr, regRd, instrValid, instrFlagSel, instrReady, microStrap;
  logic        busy, pipeFlush, testFlagOne, testFlagTwo, cacheOn, cacheFreeze;
  logic        legacyCompat, debugMask;
  logic [7:0]  regAddr, instrRepeat;
  logic [15:0] regWrData, regRdData, rdVal, lfsrState;
  logic [1:0]  instrAccSel, flagModel;
  logic [39:0] accModel [4];
  int          numErrors, checked;

  cns_core #(.NUM_ACC(4)) DUT (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .instrValid(instrValid), .instrAccSel(instrAccSel),
    .instrFlagSel(instrFlagSel), .instrRepeat(instrRepeat), .instrReady(instrReady),
    .microStrap(microStrap), .busy(busy), .pipeFlush(pipeFlush), .testFlagOne(testFlagOne),
    .testFlagTwo(testFlagTwo), .cacheOn(cacheOn), .cacheFreeze(cacheFreeze),
    .legacyCompat(legacyCompat), .debugMask(debugMask));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Returns {flag, accumulator} after the given number of steps
  function automatic logic [40:0] shiftModel(input logic [39:0] a, input int steps,
                                             input logic f);
    for (int i = 0; i < steps; i++) begin
      if (a == 40'h0) begin
        f = 1'b1;
      end else if (a[31] == a[30]) begin
        a = a << 1;
        f = 1'b0;
      end else begin
        f = 1'b1;
      end
    end
    return {f, a};
  endfunction

  task automatic tally_and_finish();
    if (numErrors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_num(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      numErrors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk_reg(what, exp, d);
  endtask

  task automatic load_acc(input int n, input logic [15:0] mid, input logic [7:0] grd);
    logic [7:0] a;
    a = 8'(cns_pkg::ADR_ACC_BASE + (n << cns_pkg::ACC_STRIDE_SH));
    wr(a, mid);
    wr(a + 8'h04, {8'h00, grd});
    accModel[n] = {grd, mid, 16'h0000};
  endtask

  task automatic run_shift(input int n, input logic fsel, input logic [7:0] rep,
                           input bit chkCnt);
    logic [40:0] r;
    logic [7:0]  a;
    int          lowCnt;
    r = shiftModel(accModel[n], int'(rep) + 1, flagModel[fsel]);
    a = 8'(cns_pkg::ADR_ACC_BASE + (n << cns_pkg::ACC_STRIDE_SH));
    @(posedge mclk);
    instrValid   <= 1'b1;
    instrAccSel  <= 2'(n);
    instrFlagSel <= fsel;
    instrRepeat  <= rep;
    lowCnt = 0;
    @(negedge mclk);
    while (instrReady !== 1'b1 && lowCnt < 100) begin
      lowCnt++;
      @(negedge mclk);
    end
    chk_bit("ready to take", 1'b1, instrReady);
    @(posedge mclk);
    instrValid <= 1'b0;
    lowCnt = 0;
    @(negedge mclk);
    while (instrReady !== 1'b1 && lowCnt < 1000) begin
      lowCnt++;
      @(negedge mclk);
    end
    chk_bit("loop ended", 1'b1, instrReady);
    // A flush beside the loop stalls it for the whole flush
    chk_num("step cycles", int'(rep) + 1 + (chkCnt ? 0 : cns_pkg::FLUSH_CYCLES), lowCnt);
    accModel[n]     = r[39:0];
    flagModel[fsel] = r[40];
    rd_chk("acc mid word", a, accModel[n][31:16]);
    rd_chk("acc guard", a + 8'h04, {8'h00, accModel[n][39:32]});
    rd_chk("flags reg", cns_pkg::ADR_FLAGS, {14'h0000, flagModel});
    chk_bit("flag one", flagModel[0], testFlagOne);
    chk_bit("flag two", flagModel[1], testFlagTwo);
  endtask

  task automatic cache_write(input logic [15:0] d);
    int cnt;
    wr(cns_pkg::ADR_CACHE, d);
    #1 chk_bit("pipe flush", 1'b1, pipeFlush);
    cnt = 0;
    repeat (8) begin
      @(negedge mclk);
      cnt += int'(busy);
    end
    chk_num("busy cycles", cns_pkg::FLUSH_CYCLES, cnt);
  endtask

  initial begin
    #400000;
    numErrors++;
    tally_and_finish();
  end

  initial begin
    logic [15:0] cacheRst;
    rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 16'h0000;
    instrValid = 1'b0; instrAccSel = 2'h0; instrFlagSel = 1'b0; instrRepeat = 8'h00;
    microStrap = 1'b1;
    lfsrState = 16'h004D;
    flagModel = 2'h3;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    cacheRst = cns_pkg::RST_CACHE | (16'h0001 << cns_pkg::MICRO_BIT);
    chk_bit("legacy out", 1'b1, legacyCompat);
    chk_bit("debug out", 1'b1, debugMask);
    chk_bit("cache on out", 1'b0, cacheOn);
    chk_bit("freeze out", 1'b0, cacheFreeze);
    rd_chk("arith reset", cns_pkg::ADR_ARITH, cns_pkg::RST_ARITH);
    rd_chk("sysctl reset", cns_pkg::ADR_SYSCTL, cns_pkg::RST_SYSCTL);
    rd_chk("cache reset", cns_pkg::ADR_CACHE, cacheRst);
    rd_chk("flags reset", cns_pkg::ADR_FLAGS, 16'h0003);
    rd_chk("state reset", cns_pkg::ADR_STATE, 16'h0000);
    rd_chk("unmapped", 8'h18, 16'h0000);
    rd_chk("unaligned", 8'h01, 16'h0000);
    lfsrState = lfsrNext(lfsrState);
    wr(cns_pkg::ADR_ARITH, lfsrState);
    rd_chk("arith rw", cns_pkg::ADR_ARITH, lfsrState);
    chk_bit("legacy follows", lfsrState[cns_pkg::LEGACY_BIT], legacyCompat);
    wr(cns_pkg::ADR_SYSCTL, 16'hFFFF);
    rd_chk("sysctl mask", cns_pkg::ADR_SYSCTL, cns_pkg::SYSCTL_RW_MASK);
    wr(cns_pkg::ADR_SYSCTL, 16'h0000);
    rd_chk("sysctl clear", cns_pkg::ADR_SYSCTL, 16'h0000);
    chk_bit("debug follows", 1'b0, debugMask);
    wr(cns_pkg::ADR_FLAGS, 16'h0002);
    flagModel = 2'h2;
    rd_chk("flags rw", cns_pkg::ADR_FLAGS, 16'h0002);
    // Set freeze and enable, then try to clear them through the protected alias
    cache_write(cacheRst | 16'hC000);
    wr(cns_pkg::ADR_CACHE_PROT, cacheRst);
    rd_chk("cache kept", cns_pkg::ADR_CACHE, cacheRst | 16'hC000);
    rd_chk("prot view", cns_pkg::ADR_CACHE_PROT, cacheRst);
    chk_bit("cache on kept", 1'b1, cacheOn);
    chk_bit("freeze kept", 1'b1, cacheFreeze);
    cache_write(cacheRst);
    wr(cns_pkg::ADR_CACHE, cacheRst);
    rd_chk("state flushing", cns_pkg::ADR_STATE, 16'h0001);
    // Corner cases: equal signs, differing signs, zero, longest repeat
    load_acc(1, 16'h1234, 8'h00);
    run_shift(1, 1'b1, 8'h00, 1'b1);
    load_acc(2, 16'h8765, 8'hFF);
    run_shift(2, 1'b1, 8'h00, 1'b1);
    run_shift(1, 1'b0, 8'h00, 1'b1);
    load_acc(0, 16'h0000, 8'h00);
    run_shift(0, 1'b0, 8'h03, 1'b1);
    load_acc(3, 16'h0001, 8'h00);
    run_shift(3, 1'b0, 8'hFF, 1'b1);
    for (int i = 0; i < 12; i++) begin
      lfsrState = lfsrNext(lfsrState);
      load_acc(int'(lfsrState[1:0]), lfsrNext(lfsrState), lfsrState[15:8]);
      run_shift(int'(lfsrState[1:0]), lfsrState[2], {4'h0, lfsrState[7:4]}, 1'b1);
    end
    // A flush landing in mid-loop must only stall the steps
    load_acc(0, 16'h0003, 8'h00);
    fork
      run_shift(0, 1'b1, 8'h28, 1'b0);
      begin
        repeat (6) @(posedge mclk);
        cache_write(cacheRst);
      end
    join
    // Second reset after the loop and the flush have ended, with the strap pin low
    @(posedge mclk);
    rst_n      <= 1'b0;
    microStrap <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rd_chk("strap low", cns_pkg::ADR_CACHE, cns_pkg::RST_CACHE);
    rd_chk("flags again", cns_pkg::ADR_FLAGS, 16'h0003);
    chk_bit("legacy again", 1'b1, legacyCompat);
    tally_and_finish();
  end
endmodule
`default_nettype wire
